// >>> rtl/irig_ctrl_pkg.sv
// constants for the time-code control-function field encoder
// Notes on behaviour
// R1 - year last two digits BCD at P50-P58
// R2 - leap pending flag high in final 59 seconds
// R3 - leap direction: 0 add, 1 remove second
// R4 - offset sign P64, binary hours P65-P68
// R5 - offset follows daylight saving, new value sent from the next P50 capture
// R6 - P70 flags extra half hour of offset
// R7 - quality code P71-P74, 1111 on failure
// R8 - P75 parity over all preceding data bits
// R9 - markers at P59, P69, P79
// R10 - unassigned positions send zero
// R11 - parity sense selectable, even by default
package irig_ctrl_pkg;
  localparam int        FIELD_W      = 30;
  localparam logic [6:0] POS_BASE    = 7'h32;
  localparam logic [6:0] POS_LAST    = 7'h4F;
  // bit positions inside the field, index 0 is frame position P50
  localparam int        F_YR_U_LSB   = 0;
  localparam int        F_YR_T_LSB   = 5;
  localparam int        F_MARK_A     = 9;
  localparam int        F_LEAP_PEND  = 10;
  localparam int        F_LEAP_DIR   = 11;
  localparam int        F_OFS_SIGN   = 14;
  localparam int        F_OFS_HR_LSB = 15;
  localparam int        F_MARK_B     = 19;
  localparam int        F_OFS_HALF   = 20;
  localparam int        F_QUAL_LSB   = 21;
  localparam int        F_PARITY     = 25;
  localparam int        F_MARK_C     = 29;
  localparam logic [29:0] MARK_MASK  = 30'h20080200;
  localparam logic [29:0] ZERO_MASK  = 30'h1C003010;
  // register byte addresses
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_YEAR      = 8'h04;
  localparam logic [7:0] A_LEAP      = 8'h08;
  localparam logic [7:0] A_OFFSET    = 8'h0C;
  localparam logic [7:0] A_QUAL      = 8'h10;
  localparam logic [7:0] A_FIELD     = 8'h14;
  // register field positions
  localparam int        LEAP_ARM_BIT = 8;
  localparam int        LEAP_DIR_BIT = 9;
  localparam int        OFS_SIGN_BIT = 4;
  localparam int        OFS_HALF_BIT = 5;
  localparam logic [7:0] LEAP_WIN_S  = 8'h3B;
  localparam logic [3:0] QUAL_FAIL   = 4'hF;
  localparam logic [3:0] QUAL_RESET  = 4'hF;
endpackage : irig_ctrl_pkg

// >>> rtl/irig_ctrl_field_pack.sv
// packs the control-function bits and parity into one field word
`timescale 1ns/1ps
module irig_ctrl_field_pack
  import irig_ctrl_pkg::*;
(
  input  wire logic [7:0]         year_bcd,
  input  wire logic               leap_pending_flag,
  input  wire logic               leap_direction_flag,
  input  wire logic               ofs_sign,
  input  wire logic [3:0]         ofs_hours,
  input  wire logic               ofs_half,
  input  wire logic [3:0]         quality,
  input  wire logic               prior_parity,
  input  wire logic               odd_parity,
  output logic      [FIELD_W-1:0] field
);
  logic [FIELD_W-1:0] data_bits;

  always_comb begin
    data_bits = '0;
    data_bits[F_YR_U_LSB +: 4]   = year_bcd[3:0]; // R1
    data_bits[F_YR_T_LSB +: 4]   = year_bcd[7:4]; // R1
    data_bits[F_LEAP_PEND]       = leap_pending_flag; // R2
    data_bits[F_LEAP_DIR]        = leap_direction_flag; // R3
    data_bits[F_OFS_SIGN]        = ofs_sign; // R4
    data_bits[F_OFS_HR_LSB +: 4] = ofs_hours; // R4
    data_bits[F_OFS_HALF]        = ofs_half; // R6
    data_bits[F_QUAL_LSB +: 4]   = quality; // R7
    field                        = data_bits;
    field[F_PARITY]              = (^data_bits) ^ prior_parity ^ odd_parity; // R8 R11
  end
endmodule : irig_ctrl_field_pack

// >>> rtl/irig_ctrl_encoder.sv
// control-function field encoder with apb register file and per-position bit output
`timescale 1ns/1ps
module irig_ctrl_encoder
  import irig_ctrl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sec_tick,
  input  wire logic        clock_fail,
  input  wire logic        pos_strobe,
  input  wire logic [6:0]  pos_index,
  input  wire logic        frame_parity_in,
  output logic             field_bit,
  output logic             marker,
  output logic             bit_valid
);
  typedef struct packed {
    logic               odd;
    logic [7:0]         year;
    logic [7:0]         leap_cnt;
    logic               leap_armed;
    logic               leap_dir;
    logic [3:0]         ofs_hr;
    logic               ofs_sign;
    logic               ofs_half;
    logic [3:0]         qual;
    logic [FIELD_W-1:0] snap;
    logic [31:0]        rdata;
    logic               ready;
    logic               err;
    logic               fbit;
    logic               mark;
    logic               valid;
  } state_t;

  state_t             st_q;
  state_t             st_d;
  logic               leap_pend;
  logic [FIELD_W-1:0] new_field;
  logic               xfer;
  logic               in_field;
  logic [6:0]         rel_idx;

  assign leap_pend = st_q.leap_armed && (st_q.leap_cnt <= LEAP_WIN_S)
                     && (st_q.leap_cnt != 8'h00); // R2
  assign xfer      = psel && penable && st_q.ready;
  assign in_field  = (pos_index >= POS_BASE) && (pos_index <= POS_LAST);
  assign rel_idx   = pos_index - POS_BASE;

  irig_ctrl_field_pack u_pack (
    .year_bcd            (st_q.year),
    .leap_pending_flag   (leap_pend),
    .leap_direction_flag (st_q.leap_dir),
    .ofs_sign            (st_q.ofs_sign),
    .ofs_hours           (st_q.ofs_hr),
    .ofs_half            (st_q.ofs_half),
    .quality             (clock_fail ? QUAL_FAIL : st_q.qual),
    .prior_parity        (frame_parity_in),
    .odd_parity          (st_q.odd),
    .field               (new_field)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d       = st_q;
    st_d.valid = 1'b0;
    // leap countdown, one step per second
    if (sec_tick && st_q.leap_armed) begin
      if (st_q.leap_cnt == 8'h00) begin
        st_d.leap_armed = 1'b0;
      end else begin
        st_d.leap_cnt = st_q.leap_cnt - 8'h01; // R2
      end
    end
    // apb: one wait cycle, then the answer
    st_d.ready = psel && penable && !st_q.ready;
    if (psel && penable && !st_q.ready) begin
      st_d.err   = 1'b0;
      st_d.rdata = '0;
      if (paddr == A_CTRL) begin
        st_d.rdata[0] = st_q.odd;
      end else if (paddr == A_YEAR) begin
        st_d.rdata[7:0] = st_q.year;
      end else if (paddr == A_LEAP) begin
        st_d.rdata = {22'h0, st_q.leap_dir, st_q.leap_armed, st_q.leap_cnt};
      end else if (paddr == A_OFFSET) begin
        st_d.rdata = {26'h0, st_q.ofs_half, st_q.ofs_sign, st_q.ofs_hr};
      end else if (paddr == A_QUAL) begin
        st_d.rdata[3:0] = st_q.qual;
      end else if (paddr == A_FIELD) begin
        st_d.rdata[FIELD_W-1:0] = st_q.snap;
      end else begin
        st_d.err = 1'b1;
      end
    end
    if (xfer && pwrite) begin
      if (paddr == A_CTRL) begin
        st_d.odd = pwdata[0]; // R11
      end else if (paddr == A_YEAR) begin
        st_d.year = pwdata[7:0]; // R1
      end else if (paddr == A_LEAP) begin
        st_d.leap_cnt   = pwdata[7:0];
        st_d.leap_armed = pwdata[LEAP_ARM_BIT];
        st_d.leap_dir   = pwdata[LEAP_DIR_BIT]; // R3
      end else if (paddr == A_OFFSET) begin
        st_d.ofs_hr   = pwdata[3:0]; // R5
        st_d.ofs_sign = pwdata[OFS_SIGN_BIT]; // R5
        st_d.ofs_half = pwdata[OFS_HALF_BIT]; // R6
      end else if (paddr == A_QUAL) begin
        st_d.qual = pwdata[3:0]; // R7
      end
    end
    // per-position output; field is captured afresh at P50 of each frame
    if (pos_strobe && in_field) begin
      st_d.valid = 1'b1;
      if (pos_index == POS_BASE) begin
        st_d.snap = new_field; // R5
        st_d.fbit = new_field[0];
        st_d.mark = 1'b0;
      end else begin
        st_d.fbit = st_q.snap[rel_idx[4:0]] & ~MARK_MASK[rel_idx[4:0]]
                    & ~ZERO_MASK[rel_idx[4:0]]; // R9 R10
        st_d.mark = MARK_MASK[rel_idx[4:0]]; // R9
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= '0;
      st_q.qual <= QUAL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata    = st_q.rdata;
  assign pready    = st_q.ready;
  assign pslverr   = st_q.err;
  assign field_bit = st_q.fbit;
  assign marker    = st_q.mark;
  assign bit_valid = st_q.valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_year_units: assert property ( // R1
    pos_strobe && pos_index == POS_BASE |=> field_bit == $past(st_q.year[0]) && bit_valid)
    else $error("year units bit wrong at first position");
  a_year_tens: assert property ( // R1
    pos_strobe && pos_index == POS_BASE |=> st_q.snap[8:5] == $past(st_q.year[7:4]))
    else $error("year tens digit not in field");
  a_leap_window: assert property ( // R2
    pos_strobe && pos_index == POS_BASE |=>
      st_q.snap[F_LEAP_PEND] == ($past(st_q.leap_armed) && $past(st_q.leap_cnt) <= LEAP_WIN_S
                                 && $past(st_q.leap_cnt) != 8'h00))
    else $error("leap pending flag outside its window");
  a_leap_dir: assert property ( // R3
    pos_strobe && pos_index == POS_BASE |=> st_q.snap[F_LEAP_DIR] == $past(st_q.leap_dir))
    else $error("leap direction not carried");
  a_offset_bits: assert property ( // R4
    pos_strobe && pos_index == POS_BASE |=>
      st_q.snap[18:14] == {$past(st_q.ofs_hr), $past(st_q.ofs_sign)})
    else $error("offset sign or hours misplaced");
  a_offset_update: assert property ( // R5
    xfer && pwrite && paddr == A_OFFSET |=> st_q.ofs_hr == $past(pwdata[3:0])
      && st_q.ofs_sign == $past(pwdata[OFS_SIGN_BIT]))
    else $error("offset write not applied");
  a_half_hour: assert property ( // R6
    pos_strobe && pos_index == POS_BASE |=> st_q.snap[F_OFS_HALF] == $past(st_q.ofs_half))
    else $error("half hour flag wrong");
  a_quality_fail: assert property ( // R7
    pos_strobe && pos_index == POS_BASE && clock_fail |=> st_q.snap[24:21] == 4'hF)
    else $error("failed clock not coded as 1111");
  a_parity_sense: assert property ( // R8 R11
    pos_strobe && pos_index == POS_BASE |=>
      ((^st_q.snap) ^ $past(frame_parity_in)) == $past(st_q.odd))
    else $error("parity does not match selected sense");
  a_marker_slots: assert property ( // R9
    pos_strobe && (pos_index == 7'h3B || pos_index == 7'h45 || pos_index == 7'h4F)
      |=> marker && !field_bit && bit_valid)
    else $error("position identifier slot not marked");
  a_unused_zero: assert property ( // R10
    pos_strobe && (pos_index == 7'h36 || pos_index == 7'h3E || pos_index == 7'h3F
      || pos_index == 7'h4C || pos_index == 7'h4D || pos_index == 7'h4E)
      |=> !field_bit && !marker)
    else $error("unassigned position not zero");

  // countdown, capture and emission checks
  a_quality_pass: assert property ( // R7
    pos_strobe && pos_index == POS_BASE && !clock_fail
      |=> st_q.snap[F_QUAL_LSB +: 4] == $past(st_q.qual))
    else $error("quality code not carried into field");
  a_leap_disarm: assert property ( // R2
    sec_tick && st_q.leap_armed && st_q.leap_cnt == 8'h00
      && !(xfer && pwrite && paddr == A_LEAP)
      |=> !st_q.leap_armed)
    else $error("leap warning not disarmed at end of countdown");
  a_leap_count: assert property ( // R2
    sec_tick && st_q.leap_armed && st_q.leap_cnt != 8'h00
      && !(xfer && pwrite && paddr == A_LEAP)
      |=> st_q.leap_cnt == $past(st_q.leap_cnt) - 8'h01)
    else $error("leap countdown did not step");
  a_field_hold: assert property ( // R5
    pos_strobe && pos_index != POS_BASE |=> st_q.snap == $past(st_q.snap))
    else $error("field changed away from its capture point");
  a_refused_pos: assert property ( // R9
    pos_strobe && (pos_index < POS_BASE || pos_index > POS_LAST) |=> !bit_valid)
    else $error("position outside the control field answered");
  a_half_emit: assert property ( // R6
    pos_strobe && pos_index == POS_BASE + 7'(F_OFS_HALF)
      |=> field_bit == $past(st_q.snap[F_OFS_HALF]) && !marker && bit_valid)
    else $error("half hour bit not sent at its position");
  a_tens_emit: assert property ( // R1
    pos_strobe && pos_index == POS_BASE + 7'(F_YR_T_LSB)
      |=> field_bit == $past(st_q.snap[F_YR_T_LSB]) && !marker && bit_valid)
    else $error("year tens bit not sent at its position");
endmodule : irig_ctrl_encoder

// >>> sim/frame_sink.sv
// partner model: frame position source and control-field receiver
`timescale 1ns/1ps
module frame_sink (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        start,
  output logic             pos_strobe,
  output logic      [6:0]  pos_index,
  input  wire logic        field_bit,
  input  wire logic        marker,
  input  wire logic        bit_valid,
  output logic      [29:0] got,
  output logic      [29:0] marks,
  output logic      [5:0]  n_valid,
  output logic             done
);
  logic [6:0] nxt_q;
  logic [6:0] held_q;
  logic       run_q;
  logic       ph_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pos_strobe <= 1'b0;
      pos_index  <= 7'h00;
      run_q      <= 1'b0;
      done       <= 1'b0;
      n_valid    <= 6'h00;
    end else begin
      pos_strobe <= 1'b0;
      pos_index  <= ~pos_index;
      if (start) begin
        run_q   <= 1'b1;
        nxt_q   <= 7'h30;
        ph_q    <= 1'b0;
        done    <= 1'b0;
        n_valid <= 6'h00;
      end else if (run_q) begin
        ph_q <= ~ph_q;
        if (!ph_q) begin
          pos_strobe <= 1'b1;
          pos_index  <= nxt_q;
          held_q     <= nxt_q;
          nxt_q      <= nxt_q + 7'h01;
        end
        if (ph_q && nxt_q == 7'h52) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end
      end
      if (bit_valid) begin
        got[held_q - 7'h32]   <= field_bit;
        marks[held_q - 7'h32] <= marker;
        n_valid               <= n_valid + 6'h01;
      end
    end
  end
endmodule : frame_sink

// >>> sim/testbench.sv
// self-checking bench for the control-function field encoder
`timescale 1ns/1ps
module testbench;
  import irig_ctrl_pkg::*;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic        sec_tick, clock_fail, frame_parity_in, start, pos_strobe;
  logic        field_bit, marker, bit_valid, done, od, fp, arm, dir, cf;
  logic [7:0]  paddr, yr, cnt;
  logic [31:0] pwdata, prdata, rv;
  logic [6:0]  pos_index;
  logic [29:0] got, marks, ef;
  logic [5:0]  n_valid, ofs;
  logic [3:0]  q;
  int          n_mismatch, n_compared, cyc;
  irig_ctrl_encoder dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sec_tick(sec_tick), .clock_fail(clock_fail),
    .pos_strobe(pos_strobe), .pos_index(pos_index), .frame_parity_in(frame_parity_in),
    .field_bit(field_bit), .marker(marker), .bit_valid(bit_valid));
  frame_sink sink (.sys_clk(sys_clk), .rstn(rstn), .start(start), .pos_strobe(pos_strobe),
    .pos_index(pos_index), .field_bit(field_bit), .marker(marker), .bit_valid(bit_valid),
    .got(got), .marks(marks), .n_valid(n_valid), .done(done));
  ////////////////////////////////////////////////////////////////////////////////
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task frame();
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    do @(posedge sys_clk); while (done !== 1'b1);
  endtask : frame
  function logic [29:0] exp_field();
    logic [29:0] f;
    f = 30'h0;
    f[3:0] = yr[3:0];
    f[8:5] = yr[7:4];
    f[10] = arm && cnt != 8'h00 && cnt <= LEAP_WIN_S;
    f[11] = dir;
    f[14] = ofs[4];
    f[18:15] = ofs[3:0];
    f[20] = ofs[5];
    f[24:21] = cf ? QUAL_FAIL : q;
    f[25] = ^f[24:0] ^ fp ^ od;
    return f;
  endfunction : exp_field
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, sec_tick, clock_fail, frame_parity_in, start} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    rstn   = 1'b0;
    void'($urandom(32'hB406));
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, A_QUAL, 32'h0);
    chk(rv, 32'h0000000F);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h00000001);
    $display("test reset and decode done");
    for (int i = 0; i < 8; i++) begin
      yr  = {4'($urandom % 10), 4'($urandom % 10)};
      yr  = (i == 1) ? 8'h99 : yr;
      ofs = 6'($urandom);
      q   = 4'($urandom);
      od  = 1'($urandom);
      fp  = 1'($urandom);
      dir = 1'($urandom);
      arm = i < 4;
      cf  = i % 4 == 3;
      cnt = (i % 4 == 0) ? 8'h3C : (i % 4 == 1) ? 8'h3B : (i % 4 == 2) ? 8'h01 : 8'h00;
      apb(1'b1, A_CTRL, {31'h0, od});
      apb(1'b1, A_YEAR, {24'h0, yr});
      apb(1'b1, A_LEAP, {22'h0, dir, arm, cnt});
      apb(1'b1, A_OFFSET, {26'h0, ofs});
      apb(1'b1, A_QUAL, {28'h0, q});
      clock_fail      <= cf;
      frame_parity_in <= fp;
      if (i == 0 || i == 3) begin
        sec_tick <= 1'b1;
        @(posedge sys_clk);
        sec_tick <= 1'b0;
        cnt = (i == 0) ? 8'h3B : 8'h00;
      end
      if (i == 3) begin
        apb(1'b0, A_LEAP, 32'h0);
        chk(rv, {22'h0, dir, 1'b0, 8'h00});
        arm = 1'b0;
      end
      frame();
      ef = exp_field();
      chk({2'h0, got & ~MARK_MASK}, {2'h0, ef});
      chk({2'h0, marks}, {2'h0, MARK_MASK});
      chk({26'h0, n_valid}, 32'h0000001E);
      apb(1'b0, A_FIELD, 32'h0);
      chk({2'h0, rv[29:0] & ~MARK_MASK}, {2'h0, ef});
      $display("test %0d done", i);
    end
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, A_QUAL, 32'h0);
    chk(rv, 32'h0000000F);
    apb(1'b0, A_YEAR, 32'h0);
    chk(rv, 32'h00000000);
    $display("test reset again done");
    report_and_stop();
  end
endmodule : testbench
